// ### rtl/standby_cfg.svh
// Purpose: offsets, field positions, reset values and timing for the standby manager
// Assumes: pclk at 10 MHz, 32-bit APB word per register
// Notes:   included by the design files and the test bench
//
// Behaviour
// - Instruction halt stops execution; peripherals keep their clock and run.
// - Entering instruction halt leaves every oscillator in its prior run state.
// - Halt ends on reset pin low, watchdog or low-supply reset, or interrupt.
// - Full hold suspends execution and all peripheral circuits.
// - Full hold entry stops ceramic, RC and crystal oscillators automatically.
// - Full hold ends on reset, lines a,b,c,e,f or port-0 interrupt.
// - Lines a and b wake a hold only in level mode, never in edge mode.
// - Crystal hold suspends execution and peripherals except the base timer.
// - Crystal hold entry stops ceramic and RC oscillators automatically.
// - Crystal oscillator keeps its entry run state throughout crystal hold.
// - Crystal hold ends on full-hold sources, base timer or remote receiver.
// - Any system reset stops the ceramic and the crystal oscillator.
// - Nine instruction-cycle lengths, each doubling, 300 ns up to 76.8 us.
// - Power-on reset is asserted only during supply power-up.
// - Power-on release level is one of eight, fixed by configuration option.
// - Low-supply reset joins power-on reset; use and seven levels by option.
// - Clock source choice includes low, medium and adjustable internal RC.
// - Adjustable RC trims in half-percent steps, measured against subclock crystal.
`ifndef STANDBY_CFG_SVH
`define STANDBY_CFG_SVH

// Register byte offsets
`define OFS_CTRL      12'h000
`define OFS_CLK       12'h004
`define OFS_TRIM      12'h008
`define OFS_MEAS      12'h00C
`define OFS_STAT      12'h010

// Control register fields
`define CTRL_HALT     0
`define CTRL_HOLD     1
`define CTRL_XHOLD    2
`define CTRL_A_LVL    3
`define CTRL_B_LVL    4

// Clock register fields
`define CLK_SRC_LO    0
`define CLK_SRC_HI    2
`define CLK_DIV_LO    4
`define CLK_DIV_HI    7
`define CLK_CF_EN     8
`define CLK_XT_EN     9
`define CLK_RC_LO     10
`define CLK_RC_HI     12

// Trim register fields
`define TRIM_LO       0
`define TRIM_HI       7
`define TRIM_CTR_LO   8
`define TRIM_CTR_HI   9
`define TRIM_GO       16

// Status register fields
`define STAT_ST_LO    0
`define STAT_ST_HI    4
`define STAT_CZ_LO    8
`define STAT_CZ_HI    11
`define STAT_POR_LO   16
`define STAT_POR_HI   18
`define STAT_LVD_EN   19
`define STAT_LVD_LO   20
`define STAT_LVD_HI   22
`define MEAS_BUSY     16

// Clock source codes
`define SRC_CERAMIC   3'h0
`define SRC_CRYSTAL   3'h1
`define SRC_RC_LOW    3'h2
`define SRC_RC_MID    3'h3
`define SRC_RC_VAR    3'h4

// Reset values
`define RST_CTRL      5'h00
`define RST_CLK       13'h0803
`define RST_TRIM      10'h080

// Timing
`define PCLK_NS       100
`define TCYC_MIN_NS   300
`define STAB_TIME_NS  204800
`define MEAS_REF_EDGES 8'h20
`define LVD_LVL_MAX   3'h6

`endif

// ### rtl/standby_pkg.sv
// Purpose: shared types of the standby manager
// Assumes: nothing beyond the cfg header
// Notes:   one-hot power states, wake and reset-source carriers
package standby_pkg;
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_HALT  = 5'b00010,
    ST_HOLD  = 5'b00100,
    ST_XHOLD = 5'b01000,
    ST_WARM  = 5'b10000
  } pwr_state_e;

  typedef struct packed {
    logic ext_irq_line_a;
    logic ext_irq_line_b;
    logic ext_irq_line_c;
    logic ext_irq_line_e;
    logic ext_irq_line_f;
    logic port0;
    logic base_timer;
    logic remote_rx;
    logic any;
  } wake_s;

  typedef struct packed {
    logic pin;
    logic wdt;
    logic low_supply_reset;
    logic por;
  } rst_src_s;
endpackage

// ### rtl/cycle_divider.sv
// Purpose: instruction-cycle tick generator with nine doubling lengths
// Assumes: BASE_CYC pclk cycles make the shortest instruction cycle
// Notes:   a new select takes effect at the next tick boundary
`include "standby_cfg.svh"
module cycle_divider #(
  parameter int BASE_CYC = `TCYC_MIN_NS / `PCLK_NS,
  parameter int N_SEL    = 9
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] sel,
  output logic            tick
);
  localparam int CW = $clog2(BASE_CYC << (N_SEL - 1));

  initial begin
    if (BASE_CYC < 1 || N_SEL < 1 || N_SEL > 16)
      $error("cycle_divider: unsupported parameters");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] top_ff;
  logic          tick_ff;
  wire  [3:0]    sel_ok = (32'(sel) < N_SEL) ? sel : 4'(N_SEL - 1);
  wire  [CW-1:0] nxt_top = CW'((BASE_CYC << sel_ok) - 1);
  wire           wrap = (cnt_ff == top_ff);

  // Select is latched only at wrap so a change never gives a short cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= '0;
      top_ff  <= CW'(BASE_CYC - 1);
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? '0 : cnt_ff + 1'b1;
      top_ff  <= wrap ? nxt_top : top_ff;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;
endmodule // cycle_divider

// ### rtl/standby_reset_clock_manager.sv
// Purpose: standby modes, internal resets and clock control behind an APB slave
// Assumes: inputs synchronous to pclk; analog detectors outside
// Notes:   outputs lag the power state by one pclk cycle
//
// Implementation choices: the address map and the APB slave port.
`include "standby_cfg.svh"
module standby_reset_clock_manager
  import standby_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int STAB_CYC   = `STAB_TIME_NS / `PCLK_NS,
  parameter int MEAS_W     = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_done,
  input  wire wake_s             wake,
  input  wire logic              reset_pin_n,
  input  wire logic              wdt_reset,
  input  wire logic              por_detect,
  input  wire logic              low_supply_detect,
  input  wire logic [2:0]        opt_por_level,
  input  wire logic              opt_lvd_en,
  input  wire logic [2:0]        opt_lvd_level,
  input  wire logic              subclock_crystal_input,
  input  wire logic              rc_var_tick,
  output logic                   sys_reset_n,
  output logic                   cpu_run,
  output logic                   periph_clk_en,
  output logic                   base_timer_clk_en,
  output logic                   ceramic_oscillator_en,
  output logic                   crystal_osc_en,
  output logic [2:0]             rc_osc_en,
  output logic [2:0]             clk_src_sel,
  output logic [7:0]             rc_trim,
  output logic [1:0]             rc_center_sel,
  output logic [2:0]             por_level_sel,
  output logic                   low_supply_reset_en,
  output logic [2:0]             low_supply_level_sel,
  output logic                   instr_tick
);
  localparam int SW = $clog2(STAB_CYC + 1);

  initial begin
    if (ADDR_W < 5 || STAB_CYC < 1 || MEAS_W < 8 || MEAS_W > 16)
      $error("standby_reset_clock_manager: unsupported parameters");
  end

  pwr_state_e        state_ff, nxt_state;
  logic [2:0]        req_ff;
  logic [1:0]        lvl_ff;
  logic [12:0]       clk_ff;
  logic [9:0]        trim_ff;
  rst_src_s          cause_ff;
  logic              por_done_ff, opt_done_ff;
  logic [2:0]        por_lvl_ff, lvd_lvl_ff;
  logic              lvd_en_ff;
  logic [SW-1:0]     stab_ff;
  logic              busy_ff, xt_prev_ff;
  logic [7:0]        edges_ff;
  logic [MEAS_W-1:0] meas_ff;
  logic              rdy_ff, err_ff, srst_ff;
  logic [31:0]       rdata_ff;
  logic              run_ff, per_ff, bt_ff, cf_ff, xt_ff;
  logic [2:0]        rc_ff;

  // APB decode: setup cycle registers the answer, access cycle completes
  wire setup   = psel & ~penable;
  wire wr_en   = psel & penable & pwrite & rdy_ff;
  wire hit_ctl = (paddr == ADDR_W'(`OFS_CTRL));
  wire hit_clk = (paddr == ADDR_W'(`OFS_CLK));
  wire hit_trm = (paddr == ADDR_W'(`OFS_TRIM));
  wire hit_mea = (paddr == ADDR_W'(`OFS_MEAS));
  wire hit_sta = (paddr == ADDR_W'(`OFS_STAT));
  wire mapped  = hit_ctl | hit_clk | hit_trm | hit_mea | hit_sta;
  wire wr_ctl  = wr_en & hit_ctl;
  wire wr_clk  = wr_en & hit_clk;
  wire wr_trm  = wr_en & hit_trm;
  wire wr_sta  = wr_en & hit_sta;

  // Reset sources; power-on only counts before its first release
  wire por_act = por_detect & ~por_done_ff;
  wire lvd_act = lvd_en_ff & low_supply_detect;
  wire pin_act = ~reset_pin_n;
  wire sys_src = pin_act | wdt_reset | lvd_act | por_act;
  wire [3:0] cause_set = {pin_act, wdt_reset, lvd_act, por_act};

  // Wake qualification per mode
  wire wk_a     = wake.ext_irq_line_a & lvl_ff[0];
  wire wk_b     = wake.ext_irq_line_b & lvl_ff[1];
  wire hold_wk  = wk_a | wk_b | wake.ext_irq_line_c | wake.ext_irq_line_e
                | wake.ext_irq_line_f | wake.port0;
  wire xhold_wk = hold_wk | wake.base_timer | wake.remote_rx;
  wire is_hold  = (state_ff == ST_HOLD);
  wire is_xhold = (state_ff == ST_XHOLD);

  // Mode entry priority: full hold, crystal hold, then halt
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (instr_done && req_ff[`CTRL_HOLD]) nxt_state = ST_HOLD;
        else if (instr_done && req_ff[`CTRL_XHOLD]) nxt_state = ST_XHOLD;
        else if (instr_done && req_ff[`CTRL_HALT]) nxt_state = ST_HALT;
      end
      ST_HALT:  if (wake.any) nxt_state = ST_RUN;
      ST_HOLD:  if (hold_wk) nxt_state = ST_WARM;
      ST_XHOLD: if (xhold_wk) nxt_state = ST_WARM;
      ST_WARM:  if (stab_ff == '0) nxt_state = ST_RUN;
      default:  nxt_state = ST_RUN;
    endcase
    if (sys_src) nxt_state = ST_RUN;
  end

  wire entered = (state_ff == ST_RUN) & (nxt_state != ST_RUN);

  // Power state and stabilisation counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RUN;
      stab_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      stab_ff  <= (nxt_state == ST_WARM && state_ff != ST_WARM) ? SW'(STAB_CYC - 1)
                : (stab_ff != '0) ? stab_ff - 1'b1 : stab_ff;
    end
  end

  // Mode requests: a write sets, entry or system reset consumes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 3'(`RST_CTRL);
      lvl_ff <= 2'h0;
    end else begin
      if (sys_src || entered) req_ff <= 3'h0;
      else if (wr_ctl) req_ff <= req_ff | pwdata[`CTRL_XHOLD:`CTRL_HALT];
      if (wr_ctl) lvl_ff <= pwdata[`CTRL_B_LVL:`CTRL_A_LVL];
    end
  end

  // Clock configuration; system reset drops ceramic and crystal enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ff <= `RST_CLK;
    end else if (sys_src) begin
      clk_ff[`CLK_CF_EN] <= 1'b0;
      clk_ff[`CLK_XT_EN] <= 1'b0;
    end else if (wr_clk) begin
      clk_ff <= pwdata[12:0];
    end
  end

  // Trim register; one step is about half a percent of the centre
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trim_ff <= `RST_TRIM;
    else if (wr_trm) trim_ff <= pwdata[`TRIM_CTR_HI:`TRIM_LO];
  end

  // Options are caught once after release, so run-time writes cannot move them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_done_ff <= 1'b0;
      por_lvl_ff  <= 3'h0;
      lvd_en_ff   <= 1'b0;
      lvd_lvl_ff  <= 3'h0;
    end else if (!opt_done_ff) begin
      opt_done_ff <= 1'b1;
      por_lvl_ff  <= opt_por_level;
      lvd_en_ff   <= opt_lvd_en & (opt_lvd_level <= `LVD_LVL_MAX);
      lvd_lvl_ff  <= (opt_lvd_level <= `LVD_LVL_MAX) ? opt_lvd_level : `LVD_LVL_MAX;
    end
  end

  // Power-on tracking and sticky causes; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_done_ff <= 1'b0;
      cause_ff    <= '0;
    end else begin
      if (!por_detect && opt_done_ff) por_done_ff <= 1'b1;
      cause_ff <= (wr_sta ? (cause_ff & ~pwdata[`STAT_CZ_HI:`STAT_CZ_LO]) : cause_ff)
                | cause_set;
    end
  end

  // Adjustable RC measured over a fixed count of subclock edges
  wire xt_rise = subclock_crystal_input & ~xt_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff    <= 1'b0;
      xt_prev_ff <= 1'b0;
      edges_ff   <= 8'h00;
      meas_ff    <= '0;
    end else begin
      xt_prev_ff <= subclock_crystal_input;
      if (wr_trm && pwdata[`TRIM_GO]) begin
        busy_ff  <= 1'b1;
        edges_ff <= 8'h00;
        meas_ff  <= '0;
      end else if (busy_ff) begin
        if (rc_var_tick && meas_ff != '1) meas_ff <= meas_ff + 1'b1;
        if (xt_rise) edges_ff <= edges_ff + 8'h01;
        if (xt_rise && edges_ff == `MEAS_REF_EDGES - 8'h01) busy_ff <= 1'b0;
      end
    end
  end

  // Read mux
  wire [31:0] rd_ctl = {27'h0, lvl_ff, req_ff};
  wire [31:0] rd_clk = {19'h0, clk_ff};
  wire [31:0] rd_trm = {15'h0, busy_ff, 6'h0, trim_ff};
  wire [31:0] rd_mea = {15'h0, busy_ff, 16'(meas_ff)};
  wire [31:0] rd_sta = {9'h0, lvd_lvl_ff, lvd_en_ff, por_lvl_ff, 4'h0, cause_ff,
                        3'h0, state_ff};
  wire [31:0] rd_val = hit_ctl ? rd_ctl : hit_clk ? rd_clk : hit_trm ? rd_trm
                     : hit_mea ? rd_mea : hit_sta ? rd_sta : 32'h0;

  // No wait state; error flagged for unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      rdy_ff   <= setup;
      err_ff   <= setup & ~mapped;
      rdata_ff <= (setup && !pwrite) ? rd_val : rdata_ff;
    end
  end

  // Oscillator and clock gating follow the power state
  wire any_hold = is_hold | is_xhold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_ff <= 1'b0;
      run_ff  <= 1'b0;
      per_ff  <= 1'b0;
      bt_ff   <= 1'b0;
      cf_ff   <= 1'b0;
      xt_ff   <= 1'b0;
      rc_ff   <= 3'h0;
    end else begin
      srst_ff <= ~sys_src;
      run_ff  <= (state_ff == ST_RUN);
      per_ff  <= (state_ff == ST_RUN) | (state_ff == ST_HALT);
      bt_ff   <= ~is_hold & (state_ff != ST_WARM);
      cf_ff   <= clk_ff[`CLK_CF_EN] & ~any_hold;
      xt_ff   <= clk_ff[`CLK_XT_EN] & ~is_hold;
      rc_ff   <= clk_ff[`CLK_RC_HI:`CLK_RC_LO] & {3{~any_hold}};
    end
  end

  cycle_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (clk_ff[`CLK_DIV_HI:`CLK_DIV_LO]),
    .tick    (instr_tick)
  );

  assign prdata                = rdata_ff;
  assign pready                = rdy_ff;
  assign pslverr               = err_ff;
  assign sys_reset_n           = srst_ff;
  assign cpu_run               = run_ff;
  assign periph_clk_en         = per_ff;
  assign base_timer_clk_en     = bt_ff;
  assign ceramic_oscillator_en = cf_ff;
  assign crystal_osc_en        = xt_ff;
  assign rc_osc_en             = rc_ff;
  assign clk_src_sel           = clk_ff[`CLK_SRC_HI:`CLK_SRC_LO];
  assign rc_trim               = trim_ff[`TRIM_HI:`TRIM_LO];
  assign rc_center_sel         = trim_ff[`TRIM_CTR_HI:`TRIM_CTR_LO];
  assign por_level_sel         = por_lvl_ff;
  assign low_supply_reset_en   = lvd_en_ff;
  assign low_supply_level_sel  = lvd_lvl_ff;

  // Checks on mode behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HALT_PERIPH: assert property (
    state_ff == ST_HALT |=> !cpu_run && periph_clk_en)
    else $error("halt must stop cpu and keep peripherals");
  AST_HALT_OSC: assert property (
    state_ff == ST_HALT && !sys_src && !wr_clk |=> cf_ff == clk_ff[`CLK_CF_EN]
      && xt_ff == clk_ff[`CLK_XT_EN])
    else $error("halt changed an oscillator");
  AST_HALT_WAKE: assert property (
    state_ff == ST_HALT && wake.any |=> state_ff == ST_RUN ##1 cpu_run)
    else $error("halt did not end on interrupt");
  AST_HOLD_ALLOFF: assert property (
    state_ff == ST_HOLD |=> !cf_ff && !xt_ff && rc_ff == 3'h0 && !per_ff && !run_ff)
    else $error("hold left something running");
  AST_EDGE_NOWAKE: assert property (
    is_hold && !sys_src && !hold_wk && wake.ext_irq_line_a |=> state_ff == ST_HOLD)
    else $error("edge line woke hold");
  AST_XHOLD_BT: assert property (
    is_xhold |=> bt_ff && !per_ff && !cf_ff && rc_ff == 3'h0)
    else $error("crystal hold gating wrong");
  AST_XHOLD_XT: assert property (
    is_xhold && $past(is_xhold) && !sys_src |=> $stable(xt_ff))
    else $error("crystal changed in crystal hold");
  AST_XHOLD_WAKE: assert property (
    is_xhold && !sys_src && (wake.base_timer || wake.remote_rx) |=> state_ff == ST_WARM)
    else $error("crystal hold missed wake");
  AST_RST_OSC: assert property (
    sys_src |=> !clk_ff[`CLK_CF_EN] && !clk_ff[`CLK_XT_EN] ##1 !cf_ff && !xt_ff)
    else $error("system reset left oscillator on");
  AST_ENTRY_WAIT: assert property (
    state_ff == ST_RUN && !instr_done |=> state_ff == ST_RUN)
    else $error("mode entered mid instruction");
  AST_WARM_HOLDOFF: assert property (
    state_ff == ST_WARM && stab_ff != '0 && !sys_src |=> state_ff == ST_WARM ##1 !cpu_run)
    else $error("resumed before stabilisation");

  // Warm-up must bring back the enabled ceramic and RC oscillators before the count runs out
  AST_WARM_RESTART: assert property (
    state_ff == ST_WARM && !sys_src && !wr_clk |=> cf_ff == clk_ff[`CLK_CF_EN]
      && rc_ff == clk_ff[`CLK_RC_HI:`CLK_RC_LO])
    else $error("oscillators not restarted in warm-up");
  AST_POR_ONLY_UP: assert property (
    por_done_ff && !pin_act && !wdt_reset && !lvd_act |=> sys_reset_n)
    else $error("power-on reset after power-up");
  AST_LVD_RESET: assert property (
    lvd_act |=> !sys_reset_n)
    else $error("low-supply reset not applied");

  COV_HALT_EXIT:  cover property (state_ff == ST_HALT ##1 state_ff == ST_RUN);
  COV_HOLD_WAKE:  cover property (state_ff == ST_HOLD ##1 state_ff == ST_WARM);
  COV_XHOLD_WAKE: cover property (state_ff == ST_XHOLD ##1 state_ff == ST_WARM);
  COV_MEAS_DONE:  cover property (busy_ff ##1 !busy_ff);
endmodule // standby_reset_clock_manager

// ### dv/standby_partner.sv
// Purpose: CPU core, wake sources and reset lines facing the standby manager
// Assumes: bench commands change just after a rising pclk edge
// Notes:   subclock and adjustable RC only toggle while their enables are high
module standby_partner
  import standby_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     stall,
  input  wire wake_s    wake_cmd,
  input  wire rst_src_s rst_cmd,
  input  wire logic     xt_on,
  input  wire logic     rc_on,
  output logic          instr_done,
  output wake_s         wake,
  output logic          reset_pin_n,
  output logic          wdt_reset,
  output logic          por_detect,
  output logic          low_supply_detect,
  output logic          subclock_crystal_input,
  output logic          rc_var_tick
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0] cnt_ff = 5'h00;

  // Free counter paces the slow oscillator models
  always_ff @(posedge pclk) begin
    cnt_ff <= cnt_ff + 5'h01;
  end

  // A stalled core never reaches an instruction boundary
  assign instr_done = ~stall;

  // The any flag follows every source, as the interrupt controller would
  always_comb begin
    wake     = wake_cmd;
    wake.any = |wake_cmd[8:1];
  end

  // Reset sources; a stopped oscillator stands low rather than holding a stale level
  assign reset_pin_n            = ~rst_cmd.pin;
  assign wdt_reset              = rst_cmd.wdt;
  assign low_supply_detect      = rst_cmd.low_supply_reset;
  assign por_detect             = rst_cmd.por;
  assign subclock_crystal_input = xt_on & cnt_ff[4];
  assign rc_var_tick            = rc_on & cnt_ff[0];
endmodule // standby_partner

// ### dv/standby_reset_clock_manager_test.sv
// Purpose: self-checking bench for the standby, reset and clock manager
// Assumes: APB answers after one access cycle; stabilisation shortened to 4 cycles
// Notes:   option straps are tied; everything else is driven in earnest
`include "standby_cfg.svh"
module standby_reset_clock_manager_test
  import standby_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, stall, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        instr_done, reset_pin_n, wdt_reset, por_detect, low_supply_detect;
  logic        subclock_crystal_input, rc_var_tick, sys_reset_n, cpu_run, instr_tick;
  logic        periph_clk_en, base_timer_clk_en, ceramic_oscillator_en, crystal_osc_en;
  logic        low_supply_reset_en, opt_lvd_en;
  logic [2:0]  rc_osc_en, clk_src_sel, por_level_sel, low_supply_level_sel;
  logic [2:0]  opt_por_level, opt_lvd_level;
  logic [7:0]  rc_trim;
  logic [1:0]  rc_center_sel;
  wake_s       wake, wake_cmd;
  rst_src_s    rst_cmd;
  int          n_errors = 0;
  int          total_checks = 0;

  standby_reset_clock_manager #(.STAB_CYC(4)) i_standby_reset_clock_manager (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_done, .wake, .reset_pin_n, .wdt_reset, .por_detect, .low_supply_detect,
    .opt_por_level, .opt_lvd_en, .opt_lvd_level, .subclock_crystal_input, .rc_var_tick,
    .sys_reset_n, .cpu_run, .periph_clk_en, .base_timer_clk_en, .ceramic_oscillator_en,
    .crystal_osc_en, .rc_osc_en, .clk_src_sel, .rc_trim, .rc_center_sel, .por_level_sel,
    .low_supply_reset_en, .low_supply_level_sel, .instr_tick
  );

  standby_partner i_standby_partner (
    .pclk, .stall, .wake_cmd, .rst_cmd, .xt_on(crystal_osc_en), .rc_on(rc_osc_en[2]),
    .instr_done, .wake, .reset_pin_n, .wdt_reset, .por_detect, .low_supply_detect,
    .subclock_crystal_input, .rc_var_tick
  );

  // Verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // A wait that ran out is a failure and ends the run
  task automatic hang();
    chk(32'h0, 32'h1);
    wrap_up();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; held until pready is seen high, then released for one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) hang();
    q = prdata;
    chk(pslverr, a > `OFS_STAT);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic waitc(input logic v);
    int i;
    for (i = 0; i < 40 && cpu_run !== v; i++) @(posedge pclk);
    if (cpu_run !== v) hang();
  endtask

  // Cycles between two instruction ticks
  task automatic gap(output int n);
    int i;
    for (i = 0; i < 2000 && instr_tick !== 1'b1; i++) @(posedge pclk);
    if (instr_tick !== 1'b1) hang();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (instr_tick !== 1'b1 && n < 2000);
    if (instr_tick !== 1'b1) hang();
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    int          d, s, m, l, n;
    logic [31:0] q;
    logic        hit;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stall = 1'b0;
    wake_cmd = '0;
    rst_cmd = rst_src_s'(4'h1);
    opt_por_level = 3'h5;
    opt_lvd_en = 1'b1;
    opt_lvd_level = 3'h2;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    chk(sys_reset_n, 1'b0);
    rst_cmd <= '0;
    cyc(4);
    chk(sys_reset_n, 1'b1);
    rd(`OFS_CLK, 32'hFFFFFFFF, 32'h00000803);
    rd(`OFS_TRIM, 32'hFFFFFFFF, 32'h00000080);
    rd(`OFS_STAT, 32'h007F001F, 32'h002D0001);
    rd(12'h014, 32'hFFFFFFFF, 32'h0);
    chk({por_level_sel, low_supply_reset_en, low_supply_level_sel}, 7'h5A);
    // A later supply dip seen by the power-on detector is ignored
    rst_cmd.por <= 1'b1;
    cyc(4);
    chk(sys_reset_n, 1'b1);
    rst_cmd.por <= 1'b0;
    wr(`OFS_STAT, 32'h00000F00);
    // Halt left by pin, watchdog and low-supply reset in turn
    for (s = 0; s < 3; s++) begin
      wr(`OFS_CLK, 32'h00000B03);
      wr(`OFS_CTRL, 32'h1);
      waitc(1'b0);
      chk({periph_clk_en, ceramic_oscillator_en, crystal_osc_en}, 3'h7);
      rst_cmd <= rst_src_s'(4'h8 >> s);
      cyc(3);
      chk({sys_reset_n, ceramic_oscillator_en, crystal_osc_en}, 3'h0);
      rst_cmd <= '0;
      waitc(1'b1);
      rd(`OFS_STAT, 32'h00000F1F, (32'h800 >> s) | 32'h1);
      wr(`OFS_STAT, 32'h00000F00);
    end
    // Entry waits for the instruction boundary; a remote-receiver interrupt ends halt
    stall <= 1'b1;
    wr(`OFS_CTRL, 32'h1);
    cyc(6);
    chk(cpu_run, 1'b1);
    stall <= 1'b0;
    waitc(1'b0);
    rd(`OFS_STAT, 32'h1F, 32'h2);
    wake_cmd.remote_rx <= 1'b1;
    waitc(1'b1);
    wake_cmd <= '0;
    // Every wake source against both holds, lines a and b in edge and level mode
    for (m = 0; m < 2; m++) begin
      for (l = 0; l < 2; l++) begin
        for (s = 1; s < 9; s++) begin
          hit = (s >= 3 && (s < 7 || l == 1)) || (m == 1 && s < 3);
          wr(`OFS_CLK, 32'h00000B03);
          wr(`OFS_CTRL, (32'h2 << m) | (l == 1 ? 32'h18 : 32'h0));
          waitc(1'b0);
          chk({periph_clk_en, base_timer_clk_en, ceramic_oscillator_en, crystal_osc_en,
               rc_osc_en}, {1'b0, m[0], 1'b0, m[0], 3'h0});
          wake_cmd <= wake_s'(9'h1 << s);
          cyc(3);
          chk({cpu_run, ceramic_oscillator_en}, {1'b0, hit});
          if (!hit) wake_cmd <= wake_s'(9'h8);
          waitc(1'b1);
          wake_cmd <= '0;
        end
      end
    end
    // Nine doubling cycle lengths; codes above eight act as eight
    for (d = 0; d < 10; d++) begin
      wr(`OFS_CLK, 32'h00000803 | d << 4);
      gap(n);
      gap(n);
      chk(n, 3 << (d > 8 ? 8 : d));
    end
    for (s = 0; s < 5; s++) begin
      wr(`OFS_CLK, 32'h00001000 | s);
      chk(clk_src_sel, s[2:0]);
    end
    // Trim, then count adjustable RC ticks against the subclock
    wr(`OFS_CLK, 32'h00001204);
    wr(`OFS_TRIM, 32'h00010237);
    chk({rc_center_sel, rc_trim}, 10'h237);
    for (d = 0; d < 600; d++) begin
      apb(1'b0, `OFS_MEAS, 32'h0, q);
      if (!q[16] && d > 2) break;
    end
    if (q[16] !== 1'b0) hang();
    chk(q[15:0] > 16'h01E0 && q[15:0] < 16'h0220, 1'b1);
    wrap_up();
  end
endmodule // standby_reset_clock_manager_test
